// File: src/tile_regs_cfg.svh
// Register numbers, frame tokens, field positions and write masks of the tile status register bank.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef TILE_REGS_CFG_SVH
`define TILE_REGS_CFG_SVH

`define TOK_WRITE        8'h24
`define TOK_READ         8'h25
`define TOK_END          8'h01
`define TOK_ACK          8'h03
`define TOK_NACK         8'h04

`define REG_TILE_CTRL    8'h02
`define REG_BOOT_STATUS  8'h03
`define REG_SECURITY     8'h05
`define REG_ROSC_CTRL    8'h06
`define REG_ROSC_COUNT   8'h07
`define ROSC_NUM         8'h04
`define REG_WP_DATA      8'h16
`define REG_STOP_MASK    8'h18
`define REG_SCRATCH      8'h20
`define REG_SCRATCH_SEL  8'hf8
`define REG_BREAKPOINT   8'h30
`define REG_BP_SEL       8'hfc

`define TC_TX_DELAY      25:18
`define TC_TX_DIV        17:9
`define TC_RGMII_EN      8
`define TC_DIV_DYNAMIC   5
`define TC_DIV_EN        4
`define TC_UTMI_SEL      2
`define TC_ULPI_EN       1
`define TC_WMASK         32'h03ff_ff36

`define SEC_WR_LOCK      31
`define SEC_DBG_BLOCK    14
`define SEC_OTP_LOCK_ALL 12
`define SEC_OTP_SECTOR   11:8
`define SEC_OTP_REDUND   7
`define SEC_OTP_BOOT     5
`define SEC_JTAG_CFG     4
`define SEC_JTAG_DAP     0
`define SEC_WMASK        32'h8000_5fb1

`define RO_CORE_EN       1
`define RO_PERIPH_EN     0
`define RO_WMASK         32'h0000_0003
`define STOP_WMASK       32'h0000_00ff
`define BP_ENABLE        0
`define CHAN_BYTES       2'h3
`define REPLY_MAX        3'h6

`endif

// File: src/tile_regs_pkg.sv
// Types shared by the tile status register bank and its oscillator counters.
// Assumes nothing beyond a SystemVerilog compiler.
package tile_regs_pkg;

    typedef struct packed {
        logic       ctrl;
        logic [7:0] value;
    } tok_t;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_CHAN  = 7'b0000010,
        ST_REGN  = 7'b0000100,
        ST_SIZE  = 7'b0001000,
        ST_PAYLD = 7'b0010000,
        ST_DRAIN = 7'b0100000,
        ST_REPLY = 7'b1000000
    } frame_state_t;

    typedef struct packed {
        logic [7:0] processor;
        logic       mode_override;
        logic       core1_off;
        logic       skip_otp_poll;
        logic       boot_ram;
        logic       boot_jtag;
        logic [1:0] pll_mode;
    } boot_straps_t;

    typedef struct packed {
        logic       otp_lock_all;
        logic [3:0] otp_sector_lock;
        logic       otp_redundancy;
        logic       global_debug_block;
        logic       force_otp_boot;
        logic       jtag_cfg_block;
        logic       jtag_dap_block;
    } sec_ctl_t;

    typedef struct packed {
        logic [7:0] tx_delay;
        logic       tx_clk;
        logic       port_enable;
        logic       utmi_select;
        logic       ulpi_enable;
        logic       clkdiv_active;
    } tile_ctl_t;

    typedef struct packed {
        frame_state_t    state;
        logic            is_write;
        logic            bad;
        logic [1:0]      chan_cnt;
        logic [23:0]     chan;
        logic [7:0]      regn;
        logic [7:0]      size;
        logic [31:0]     wdata;
        tok_t [5:0]      rbuf;
        logic [2:0]      rcnt;
        logic [23:0]     rchan;
        logic [31:0]     tile_ctrl;
        boot_straps_t    boot;
        logic [31:0]     sec;
        logic [1:0]      rosc_ctrl;
        logic [31:0]     wp_data;
        logic [7:0]      stop_mask;
        logic [7:0][31:0] scratch;
        logic [3:0][31:0] bp;
        logic [8:0]      tx_cnt;
        tile_ctl_t       ctl;
        logic [7:0]      thread_hold;
        logic [3:0]      bp_hit;
    } tile_state_t;

    typedef struct packed {
        logic [2:0]  sync;
        logic        level;
        logic [31:0] count;
    } osc_state_t;

endpackage : tile_regs_pkg

// File: src/osc_counter.sv
// One ring oscillator counter: synchronises the oscillator and counts its rising edges while enabled.
// Assumes the oscillator toggles well below a quarter of the core clock rate.
`timescale 1ns/1ps
`include "tile_regs_cfg.svh"
module osc_counter
    import tile_regs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        osc,
    input  wire logic        enable,
    output logic [31:0]      count
);
    // The count starts from zero here; in silicon it wakes up arbitrary, which software must allow for.
    osc_state_t q = '0;
    osc_state_t next_q;

    always_comb begin
        next_q = q;
        next_q.sync = {q.sync[1:0], osc};
        // A change is taken only once the second and third stages agree.
        if (q.sync[1] == q.sync[2] && q.sync[2] != q.level) begin
            next_q.level = q.sync[2];
            if (q.sync[2] && enable) begin
                next_q.count = q.count + 32'h1;
            end
        end
    end

    // The count is left out of the reset so that it survives a system reset.
    always_ff @(posedge clock) begin
        q <= next_q;
        if (srst) begin
            q.sync  <= 3'h0;
            q.level <= 1'b0;
        end
    end

    assign count = q.count;

    count_step_a: assert property (@(posedge clock) disable iff (srst)
        !enable |=> $stable(q.count)) else $error("Counter moved while oscillator stopped.");
    count_keep_a: assert property (@(posedge clock) $rose(srst) |=> $stable(q.count))
        else $error("Counter changed across reset.");

endmodule : osc_counter

// File: src/tile_status_register_bank.sv
// Tile status register bank reached by token-framed configuration read and write messages.
// Assumes one token offered at a time with valid/ready, and replies drained through valid/ready.
//
// What this block does
// - Write frame: token 36, 24-bit reply channel, register, size, payload, token 1.
// - Write reply is tokens 3,1 on success or tokens 4,1 on failure.
// - Read frame: token 36+1, reply channel, register, size, token 1, no payload.
// - Read reply is token 3, register data, token 1, or tokens 4,1 on failure.
// - Tile control bits 25:18 give the RGMII transmit data delay; reset zero.
// - TX clock rises at divider value, falls at half of it; value is ratio minus one.
// - Tile control bit 8 enables the RGMII ports; reset zero.
// - Bit 4 enables clock division; bit 5 limits it to all threads paused.
// - Bit 2 selects UTMI over ULPI; bit 1 enables ULPI support hardware.
// - Boot status is read-only: processor number, override, core1 off, boot sources, PLL mode.
// - Security register loads a copy of the OTP security word.
// - Security bit 31 blocks any later write to the security register.
// - Security bits lock all or single OTP sectors and enable OTP redundancy.
// - Security bits block global debug, force OTP boot, block JTAG access paths.
// - Four oscillators each clock a counter; control bits 1 and 0 run them.
// - Oscillator counts are kept through system reset.
// - Watchpoint data captures access address or resource identifier.
// - Stop mask bits keep threads halted outside debug mode after debug return.
// - Eight shared 32-bit debug scratch registers.
// - Four breakpoints each raise a debug interrupt when the PC matches.
`timescale 1ns/1ps
`include "tile_regs_cfg.svh"
module tile_status_register_bank
    import tile_regs_pkg::*;
#(
    parameter int THREADS = 8,
    parameter int BREAKS  = 4
) (
    input  wire logic               clock,
    input  wire logic               srst,
    input  wire logic               tok_valid,
    input  tok_t                    tok,
    output logic                    tok_ready,
    output logic                    rsp_valid,
    output tok_t                    rsp,
    output logic [23:0]             rsp_chan,
    input  wire logic               rsp_ready,
    input  boot_straps_t            boot_straps,
    input  wire logic               otp_load,
    input  wire logic [31:0]        otp_security_word,
    input  wire logic [3:0]         ring_osc,
    input  wire logic               all_threads_paused,
    input  wire logic               debug_mode,
    input  wire logic               data_wp_hit,
    input  wire logic [31:0]        wp_address,
    input  wire logic               res_wp_hit,
    input  wire logic [31:0]        wp_resource,
    input  wire logic               pc_valid,
    input  wire logic [31:0]        pc,
    output tile_ctl_t               tile_ctl,
    output sec_ctl_t                sec_ctl,
    output logic [THREADS-1:0]      thread_hold,
    output logic [BREAKS-1:0]       bp_hit,
    output logic                    debug_irq
);
    tile_state_t q;
    tile_state_t next_q;
    logic [3:0][31:0] rosc_count;
    logic [3:0]       bp_match;
    logic             take;
    logic             rsp_fire;
    logic             acc_ok;
    logic [31:0]      rd_data;
    logic [7:0]       rosc_idx;

    // Oscillators 0 and 2 follow the core enable, 1 and 3 the peripheral enable.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_osc
            osc_counter u_osc (
                .clock  (clock),
                .srst   (srst),
                .osc    (ring_osc[gi]),
                .enable (q.rosc_ctrl[(gi % 2 == 0) ? `RO_CORE_EN : `RO_PERIPH_EN]),
                .count  (rosc_count[gi])
            );
        end
        for (gi = 0; gi < 4; gi++) begin : g_bp
            // Bit 0 of an instruction address is always zero, so it serves as the enable.
            assign bp_match[gi] = pc_valid && q.bp[gi][`BP_ENABLE] &&
                                  (pc[31:1] == q.bp[gi][31:1]);
        end
    endgenerate

    assign take      = tok_valid && tok_ready;
    assign rsp_fire  = rsp_valid && rsp_ready;
    assign tok_ready = (q.state != ST_REPLY);
    assign rsp_valid = (q.rcnt != 3'h0);
    assign rsp       = q.rbuf[0];
    assign rsp_chan  = q.rchan;
    assign rosc_idx  = q.regn - `REG_ROSC_COUNT;

    // Read mux and access check; unmapped numbers fail.
    always_comb begin
        acc_ok  = 1'b1;
        rd_data = 32'h0;
        if ((q.regn & `REG_SCRATCH_SEL) == `REG_SCRATCH) begin
            rd_data = q.scratch[q.regn[2:0]];
        end else if ((q.regn & `REG_BP_SEL) == `REG_BREAKPOINT) begin
            rd_data = q.bp[q.regn[1:0]];
        end else if (q.regn >= `REG_ROSC_COUNT && q.regn < `REG_ROSC_COUNT + `ROSC_NUM) begin
            rd_data = rosc_count[rosc_idx[1:0]];
            acc_ok  = !q.is_write;
        end else begin
            unique case (q.regn)
                `REG_TILE_CTRL: rd_data = q.tile_ctrl & `TC_WMASK;
                `REG_BOOT_STATUS: begin
                    rd_data = {8'h0, q.boot.processor, 7'h0, q.boot.mode_override, 2'h0,
                               q.boot.core1_off, q.boot.skip_otp_poll, q.boot.boot_ram,
                               q.boot.boot_jtag, q.boot.pll_mode};
                    acc_ok  = !q.is_write;
                end
                `REG_SECURITY: begin
                    rd_data = q.sec & `SEC_WMASK;
                    acc_ok  = !(q.is_write && q.sec[`SEC_WR_LOCK]);
                end
                `REG_ROSC_CTRL: rd_data = {30'h0, q.rosc_ctrl};
                `REG_WP_DATA:   rd_data = q.wp_data;
                `REG_STOP_MASK: rd_data = {24'h0, q.stop_mask};
                default:        acc_ok = 1'b0;
            endcase
        end
    end

    always_comb begin
        next_q = q;
        next_q.bp_hit = bp_match;
        // Drain the reply one token per accepted handshake.
        if (rsp_fire) begin
            next_q.rbuf = {tok_t'('0), q.rbuf[5:1]};
            next_q.rcnt = q.rcnt - 3'h1;
        end
        if (take) begin
            unique case (q.state)
                ST_IDLE: begin
                    // Stray tokens between frames are dropped.
                    if (tok.ctrl && (tok.value == `TOK_WRITE || tok.value == `TOK_READ)) begin
                        next_q.state    = ST_CHAN;
                        next_q.is_write = (tok.value == `TOK_WRITE);
                        next_q.bad      = 1'b0;
                        next_q.chan_cnt = 2'h0;
                        next_q.wdata    = 32'h0;
                    end
                end
                ST_CHAN, ST_REGN, ST_SIZE: begin
                    if (tok.ctrl) begin
                        next_q.bad   = 1'b1;
                        next_q.state = (tok.value == `TOK_END) ? ST_REPLY : ST_DRAIN;
                    end else if (q.state == ST_CHAN) begin
                        next_q.chan     = {q.chan[15:0], tok.value};
                        next_q.chan_cnt = q.chan_cnt + 2'h1;
                        if (q.chan_cnt == `CHAN_BYTES - 2'h1) begin
                            next_q.state = ST_REGN;
                        end
                    end else if (q.state == ST_REGN) begin
                        next_q.regn  = tok.value;
                        next_q.state = ST_SIZE;
                    end else begin
                        next_q.size  = tok.value;
                        next_q.state = ST_PAYLD;
                    end
                end
                ST_PAYLD: begin
                    if (tok.ctrl) begin
                        next_q.bad   = q.bad || (tok.value != `TOK_END);
                        next_q.state = (tok.value == `TOK_END) ? ST_REPLY : ST_DRAIN;
                    end else begin
                        // Payload bytes arrive most significant first; the last four count.
                        next_q.wdata = {q.wdata[23:0], tok.value};
                        next_q.bad   = q.bad || !q.is_write;
                    end
                end
                ST_DRAIN: begin
                    if (tok.ctrl && tok.value == `TOK_END) begin
                        next_q.state = ST_REPLY;
                    end
                end
                ST_REPLY: ;
                default: next_q.state = ST_IDLE;
            endcase
        end
        // The first cycle after the closing token with no reply left to drain: perform the access and build the reply.
        if (q.state == ST_REPLY && q.rcnt == 3'h0) begin
            if (next_q.rcnt == 3'h0 && !rsp_fire) begin
                next_q.state = ST_IDLE;
                next_q.rchan = q.chan;
                if (q.bad || !acc_ok) begin
                    next_q.rbuf = {tok_t'('0), tok_t'('0), tok_t'('0), tok_t'('0),
                                   tok_t'({1'b1, `TOK_END}), tok_t'({1'b1, `TOK_NACK})};
                    next_q.rcnt = 3'h2;
                end else if (q.is_write) begin
                    next_q.rbuf = {tok_t'('0), tok_t'('0), tok_t'('0), tok_t'('0),
                                   tok_t'({1'b1, `TOK_END}), tok_t'({1'b1, `TOK_ACK})};
                    next_q.rcnt = 3'h2;
                    if ((q.regn & `REG_SCRATCH_SEL) == `REG_SCRATCH) begin
                        next_q.scratch[q.regn[2:0]] = q.wdata;
                    end else if ((q.regn & `REG_BP_SEL) == `REG_BREAKPOINT) begin
                        next_q.bp[q.regn[1:0]] = q.wdata;
                    end else begin
                        unique case (q.regn)
                            `REG_TILE_CTRL: next_q.tile_ctrl = q.wdata & `TC_WMASK;
                            `REG_SECURITY:  next_q.sec = q.wdata & `SEC_WMASK;
                            `REG_ROSC_CTRL: next_q.rosc_ctrl = 2'(q.wdata & `RO_WMASK);
                            `REG_WP_DATA:   next_q.wp_data = q.wdata;
                            `REG_STOP_MASK: next_q.stop_mask = q.wdata[7:0];
                            default: ;
                        endcase
                    end
                end else begin
                    next_q.rbuf = {tok_t'('0), tok_t'({1'b1, `TOK_END}),
                                   tok_t'({1'b0, rd_data[7:0]}), tok_t'({1'b0, rd_data[15:8]}),
                                   tok_t'({1'b0, rd_data[23:16]}), tok_t'({1'b0, rd_data[31:24]})};
                    next_q.rbuf = {next_q.rbuf[4:0], tok_t'({1'b1, `TOK_ACK})};
                    next_q.rcnt = `REPLY_MAX;
                end
            end
        end
        // A hardware capture wins over a register write in the same cycle.
        if (data_wp_hit) begin
            next_q.wp_data = wp_address;
        end else if (res_wp_hit) begin
            next_q.wp_data = wp_resource;
        end
        if (otp_load) begin
            next_q.sec = otp_security_word & `SEC_WMASK;
        end
        // Transmit clock divider: rise at the value, fall at half of it.
        if (!q.tile_ctrl[`TC_RGMII_EN]) begin
            next_q.tx_cnt     = 9'h0;
            next_q.ctl.tx_clk = 1'b0;
        end else if (q.tx_cnt == q.tile_ctrl[`TC_TX_DIV]) begin
            next_q.tx_cnt     = 9'h0;
            next_q.ctl.tx_clk = 1'b1;
        end else begin
            next_q.tx_cnt = q.tx_cnt + 9'h1;
            if (q.tx_cnt == (q.tile_ctrl[`TC_TX_DIV] >> 1)) begin
                next_q.ctl.tx_clk = 1'b0;
            end
        end
        next_q.ctl.tx_delay      = q.tile_ctrl[`TC_TX_DELAY];
        next_q.ctl.port_enable   = q.tile_ctrl[`TC_RGMII_EN];
        next_q.ctl.utmi_select   = q.tile_ctrl[`TC_UTMI_SEL];
        next_q.ctl.ulpi_enable   = q.tile_ctrl[`TC_ULPI_EN];
        next_q.ctl.clkdiv_active = q.tile_ctrl[`TC_DIV_EN] &&
                                   (!q.tile_ctrl[`TC_DIV_DYNAMIC] || all_threads_paused);
        next_q.thread_hold       = debug_mode ? 8'h0 : q.stop_mask;
    end

    // Straps are caught while reset is held, so the boot status is fixed from release onward.
    always_ff @(posedge clock) begin
        if (srst) begin
            q            <= '0;
            q.state      <= ST_IDLE;
            q.boot       <= boot_straps;
            q.scratch    <= q.scratch;
        end else begin
            q <= next_q;
        end
    end

    assign tile_ctl    = q.ctl;
    assign sec_ctl     = '{otp_lock_all:       q.sec[`SEC_OTP_LOCK_ALL],
                           otp_sector_lock:    q.sec[`SEC_OTP_SECTOR],
                           otp_redundancy:     q.sec[`SEC_OTP_REDUND],
                           global_debug_block: q.sec[`SEC_DBG_BLOCK],
                           force_otp_boot:     q.sec[`SEC_OTP_BOOT],
                           jtag_cfg_block:     q.sec[`SEC_JTAG_CFG],
                           jtag_dap_block:     q.sec[`SEC_JTAG_DAP]};
    assign thread_hold = q.thread_hold[THREADS-1:0];
    assign bp_hit      = q.bp_hit[BREAKS-1:0];
    assign debug_irq   = |q.bp_hit;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    frame_open_a: assert property (take && q.state == ST_IDLE && tok.ctrl && tok.value == `TOK_WRITE
        |=> q.state == ST_CHAN && q.is_write) else $error("Write frame not opened.");
    read_open_a: assert property (take && q.state == ST_IDLE && tok.ctrl && tok.value == `TOK_READ
        |=> q.state == ST_CHAN && !q.is_write) else $error("Read frame not opened.");
    reply_head_a: assert property (take && q.state == ST_PAYLD && tok.ctrl && tok.value == `TOK_END
        |-> ##2 rsp_valid && rsp.ctrl && (rsp.value == `TOK_ACK || rsp.value == `TOK_NACK))
        else $error("Reply did not start with an acknowledge token.");
    nack_pair_a: assert property (rsp_fire && rsp.ctrl && rsp.value == `TOK_NACK
        |=> rsp_valid && rsp.ctrl && rsp.value == `TOK_END) else $error("Failure reply not closed.");
    boot_fixed_a: assert property (##1 $stable(q.boot)) else $error("Boot status changed.");
    sec_lock_a: assert property (q.sec[`SEC_WR_LOCK] && !otp_load
        |=> $stable(q.sec)) else $error("Locked security register changed.");
    wp_capture_a: assert property (data_wp_hit |=> q.wp_data == $past(wp_address))
        else $error("Watchpoint address not captured.");
    txclk_rise_a: assert property (q.tile_ctrl[`TC_RGMII_EN] && q.tx_cnt == q.tile_ctrl[`TC_TX_DIV]
        |=> q.ctl.tx_clk && q.tx_cnt == 9'h0) else $error("Transmit clock did not rise.");
    clkdiv_mode_a: assert property (q.tile_ctrl[`TC_DIV_EN] && !q.tile_ctrl[`TC_DIV_DYNAMIC]
        |=> q.ctl.clkdiv_active) else $error("Static clock division not applied.");
    reserved_zero_a: assert property ((q.tile_ctrl & ~`TC_WMASK) == 32'h0)
        else $error("Reserved tile control bits set.");
    bp_irq_a: assert property (|bp_match |=> debug_irq) else $error("Breakpoint missed.");

    write_ok_c: cover property (rsp_fire && rsp.value == `TOK_ACK && q.rcnt == 3'h2);
    read_ok_c:  cover property (rsp_fire && rsp.value == `TOK_ACK && q.rcnt == `REPLY_MAX);
    fail_c:     cover property (rsp_fire && rsp.ctrl && rsp.value == `TOK_NACK);

endmodule : tile_status_register_bank

// File: dv/cfg_master.sv
// Far-side model: sends configuration frames token by token and drains replies into got.
// Assumes the bank takes a token at an edge where tok_valid and tok_ready are high.
// Assumes every call starts just after a clock edge; each token task returns just after one too.
`timescale 1ns/1ps
module cfg_master
    import tile_regs_pkg::*;
(
    input  wire logic clock,
    output logic      tok_valid,
    output tok_t      tok,
    input  wire logic tok_ready,
    input  wire logic rsp_valid,
    input  tok_t      rsp,
    output logic      rsp_ready
);
    tok_t got[$];
    logic slow = 1'b0;
    initial tok_valid = 1'b0;
    initial tok = '0;
    initial rsp_ready = 1'b1;
    // Stalling every other cycle shows that a reply token holds until taken.
    always @(posedge clock) rsp_ready <= !(slow && rsp_ready);
    always @(posedge clock) if (rsp_valid && rsp_ready) got.push_back(rsp);
    task automatic put(input logic c, input logic [7:0] v);
        tok_valid = 1'b1;
        tok = '{c, v};
        @(posedge clock);
        while (tok_ready !== 1'b1) @(posedge clock);
        #1;
    endtask : put
    task automatic xfer(input logic wr, input logic [7:0] rn, input logic [31:0] d);
        got = {};
        put(1'b1, wr ? 8'h24 : 8'h25);
        for (int i = 2; i >= 0; i--) put(1'b0, 8'h5a + 8'(i));
        put(1'b0, rn);
        put(1'b0, 8'h04);
        if (wr) for (int i = 3; i >= 0; i--) put(1'b0, d[8*i +: 8]);
        put(1'b1, 8'h01);
        tok_valid = 1'b0;
        for (int i = 0; i < 300 && !(got.size() > 0 && got[$] === 9'h101); i++) @(posedge clock);
        #1;
    endtask : xfer
endmodule : cfg_master

// File: dv/tb_top.sv
// Self-checking bench for the tile status register bank: a table of register cases, then hand tests.
// Assumes the far-side model cfg_master drives the token link.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top
    import tile_regs_pkg::*;
;
    typedef struct packed {logic [7:0] rn; logic [31:0] wd; logic [31:0] rd; logic ok;} row_t;
    row_t rows[9] = '{'{8'h02, 32'hffffffff, 32'h03ffff36, 1'b1}, '{8'h03, 32'hffffffff, 32'h002a012a, 1'b0},
        '{8'h06, 32'hffffffff, 32'h00000003, 1'b1}, '{8'h16, 32'h12345678, 32'h12345678, 1'b1},
        '{8'h18, 32'hffffffff, 32'h000000ff, 1'b1}, '{8'h20, 32'ha5a5a5a5, 32'ha5a5a5a5, 1'b1},
        '{8'h27, 32'h5a5a0001, 32'h5a5a0001, 1'b1}, '{8'h30, 32'h00001001, 32'h00001001, 1'b1},
        '{8'h33, 32'h00002001, 32'h00002001, 1'b1}};
    logic        clock = 1'b0, srst = 1'b1, otp_load = 1'b0, paused = 1'b0, dbg = 1'b0;
    logic        data_hit = 1'b0, res_hit = 1'b0, pc_valid = 1'b0;
    logic [3:0]  ring_osc = 4'h0;
    logic [31:0] otp_word = 32'h0, pc = 32'h0, q, q1;
    logic        tok_valid, tok_ready, rsp_valid, rsp_ready, debug_irq;
    tok_t        tok, rsp;
    tile_ctl_t   tile_ctl;
    sec_ctl_t    sec_ctl;
    logic [7:0]  thread_hold;
    logic [3:0]  bp_hit;
    logic [23:0] rsp_chan;
    int          n_fail = 0, n_checks = 0;
    initial forever #2.5 clock = ~clock;
    // Slow enough for the three-flop synchroniser in front of each counter.
    always #20 ring_osc = ~ring_osc;
    tile_status_register_bank u_dut (.clock(clock), .srst(srst), .tok_valid(tok_valid), .tok(tok),
        .tok_ready(tok_ready), .rsp_valid(rsp_valid), .rsp(rsp), .rsp_chan(rsp_chan), .rsp_ready(rsp_ready),
        .boot_straps(15'h156a), .otp_load(otp_load), .otp_security_word(otp_word), .ring_osc(ring_osc),
        .all_threads_paused(paused), .debug_mode(dbg), .data_wp_hit(data_hit), .wp_address(32'hcafe0010),
        .res_wp_hit(res_hit), .wp_resource(32'h00000b07), .pc_valid(pc_valid), .pc(pc), .tile_ctl(tile_ctl),
        .sec_ctl(sec_ctl), .thread_hold(thread_hold), .bp_hit(bp_hit), .debug_irq(debug_irq));
    cfg_master u_far (.clock(clock), .tok_valid(tok_valid), .tok(tok), .tok_ready(tok_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic rd(input logic [7:0] rn);
        u_far.xfer(1'b0, rn, 32'h0);
        q = {u_far.got[1].value, u_far.got[2].value, u_far.got[3].value, u_far.got[4].value};
        `CHK("read frame", {9'h103, 9'h101}, {u_far.got[0], u_far.got[5]})
        `CHK("reply chan", 24'h5c5b5a, rsp_chan)
    endtask : rd
    task automatic wr(input logic [7:0] rn, input logic [31:0] d, input logic [8:0] e);
        u_far.xfer(1'b1, rn, d);
        `CHK("write reply", {e, 9'h101}, {u_far.got[0], u_far.got[1]})
    endtask : wr
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        complete_run();
    end
    initial begin
        tick(8);
        srst = 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].rn, rows[i].wd, rows[i].ok ? 9'h103 : 9'h104);
            rd(rows[i].rn);
            `CHK("read data", rows[i].rd, q)
        end
        $display("table done");
        tick(3);
        `CHK("tile ctl", 12'hffe, {tile_ctl.tx_delay, tile_ctl[3:0]})
        paused = 1'b1;
        tick(3);
        `CHK("divider", 1'b1, tile_ctl.clkdiv_active)
        `CHK("hold", 8'hff, thread_hold)
        dbg = 1'b1;
        pc = 32'h1000;
        pc_valid = 1'b1;
        tick(3);
        `CHK("hold dbg", 8'h00, thread_hold)
        `CHK("bp", 5'h11, {debug_irq, bp_hit})
        pc = 32'h1004;
        data_hit = 1'b1;
        tick(1);
        data_hit = 1'b0;
        tick(2);
        `CHK("bp off", 1'b0, debug_irq)
        rd(8'h16);
        `CHK("wp addr", 32'hcafe0010, q)
        res_hit = 1'b1;
        tick(1);
        res_hit = 1'b0;
        rd(8'h16);
        `CHK("wp res", 32'h00000b07, q)
        $display("debug done");
        u_far.slow = 1'b1;
        otp_word = 32'h00005fb1;
        otp_load = 1'b1;
        tick(1);
        otp_load = 1'b0;
        tick(2);
        `CHK("sec ctl", 10'h3ff, sec_ctl)
        rd(8'h05);
        `CHK("sec copy", 32'h00005fb1, q)
        wr(8'h05, 32'h80000000, 9'h103);
        wr(8'h05, 32'h00000001, 9'h104);
        rd(8'h05);
        `CHK("sec lock", 32'h80000000, q)
        `CHK("sec off", 10'h000, sec_ctl)
        u_far.xfer(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 9'h104, u_far.got[0])
        u_far.slow = 1'b0;
        $display("security done");
        wr(8'h06, 32'h0, 9'h103);
        tick(10);
        rd(8'h07);
        q1 = q;
        `CHK("count ran", 1'b1, q1 !== 32'h0)
        rd(8'h07);
        `CHK("count still", q1, q)
        srst = 1'b1;
        tick(8);
        srst = 1'b0;
        rd(8'h07);
        `CHK("count kept", q1, q)
        rd(8'h02);
        `CHK("ctrl reset", 32'h0, q)
        $display("oscillator done");
        complete_run();
    end
endmodule : tb_top
